/* File: hdl/cie_core.sv */
// Local design decisions: the register offsets and the Avalon-MM register port.
module cie_core #(
    parameter int NUM_SRC = 8,
    parameter logic [NUM_SRC-1:0] LEVEL_MASK = '0,
    parameter logic [15:0] BOOT_START = 16'hF000
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire cie_pkg::cie_avs_req_type avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // configuration straps
    input wire logic boot_reset_fuse_i,
    input wire logic app_section_lock_bit_i,
    input wire logic boot_section_lock_bit_i,
    // interrupt sources
    input wire logic [NUM_SRC-1:0] src_event_i,
    input wire logic [NUM_SRC-1:0] src_level_i,
    output logic [NUM_SRC-1:0] src_ack_o,
    // cpu pipeline
    input wire cie_pkg::cie_cpu_type cpu_i,
    input wire logic [15:0] cpu_pc_i,
    output logic cpu_stall_o,
    output logic cpu_wake_o,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic [15:0] sp_o,
    output logic global_enable_o,
    // stack memory
    output cie_pkg::cie_mem_type mem_o,
    input wire logic [7:0] mem_rdata_i
);
    import cie_pkg::*;

    localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

    typedef struct packed {
        cie_state_type st;
        logic [1:0] cnt;
        logic gie;
        logic vsel;
        logic [NUM_SRC-1:0] en;
        logic [NUM_SRC-1:0] flags;
        logic [NUM_SRC-1:0] ack;
        logic [IDX_W-1:0] idx;
        logic [15:0] sp;
        logic [15:0] ret_pc;
        logic [7:0] pop_hi;
        logic pc_load;
        logic [15:0] pc_val;
        cie_mem_type mem;
        logic bus_ack;
        logic [31:0] rdata;
    } cie_core_state_type;

    cie_core_state_type cur_ff;
    cie_core_state_type nxt_ff;

    logic [NUM_SRC-1:0] req;
    logic [IDX_W-1:0] win_idx;
    logic lock_sup;
    logic take;
    logic [15:0] vec_base;
    logic [15:0] rst_vec;
    logic bus_req;

    // highest priority pending source: lowest index wins
    function automatic logic [IDX_W-1:0] pick(input logic [NUM_SRC-1:0] r);
        logic [IDX_W-1:0] w;
        w = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (r[i])
            begin
                w = IDX_W'(i);
            end
        end
        return w;
    endfunction

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // request qualification
    // level sources bypass the flag store, so a vanished level never fires
    assign req = ((cur_ff.flags & ~LEVEL_MASK)
                 | (src_level_i & LEVEL_MASK)) & cur_ff.en;
    assign win_idx = pick(req);
    assign vec_base = cur_ff.vsel ? BOOT_START : CIE_APP_VEC_BASE;
    assign rst_vec = boot_reset_fuse_i ? BOOT_START : CIE_APP_VEC_BASE;
    // lock bits block taking vectors that live in the other section
    assign lock_sup = (app_section_lock_bit_i && !cur_ff.vsel
                       && cpu_pc_i >= BOOT_START)
                    || (boot_section_lock_bit_i && cur_ff.vsel
                        && cpu_pc_i < BOOT_START);
    // only at an instruction end, or from sleep; a cli in flight wins
    assign take = (cur_ff.st == CIE_ST_IDLE)
                  && (cpu_i.boundary || cpu_i.sleeping)
                  && cur_ff.gie && !cpu_i.op_cli
                  && !cpu_i.op_return_from_handler_op && (req != '0) && !lock_sup;
    assign bus_req = avs_req_i.read || avs_req_i.write;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        nxt_ff = cur_ff;
        nxt_ff.ack = '0;
        nxt_ff.pc_load = 1'b0;
        nxt_ff.mem.we = 1'b0;
        nxt_ff.mem.re = 1'b0;
        nxt_ff.bus_ack = bus_req && !cur_ff.bus_ack;

        // read data prepared in the wait cycle, presented with the ack
        unique case (avs_req_i.address)
            CIE_OFS_CTRL:
                nxt_ff.rdata = 32'({cur_ff.vsel, cur_ff.gie});
            CIE_OFS_ENABLE:
                nxt_ff.rdata = 32'(cur_ff.en);
            CIE_OFS_FLAGS:
                nxt_ff.rdata = 32'(cur_ff.flags);
            CIE_OFS_STATUS:
                nxt_ff.rdata = 32'({cur_ff.idx, 5'h00, cur_ff.st});
            CIE_OFS_SP:
                nxt_ff.rdata = 32'(cur_ff.sp);
            default:
                nxt_ff.rdata = CIE_UNMAPPED_VAL;
        endcase

        // software writes commit on the ack cycle only
        if (avs_req_i.write && cur_ff.bus_ack)
        begin
            unique case (avs_req_i.address)
                CIE_OFS_CTRL:
                begin
                    if (avs_req_i.byteenable[0])
                    begin
                        nxt_ff.gie =
                            avs_req_i.writedata[CIE_CTRL_GIE_BIT];
                        nxt_ff.vsel = avs_req_i.writedata[CIE_CTRL_VSEL_BIT];
                    end
                end
                CIE_OFS_ENABLE:
                    nxt_ff.en = NUM_SRC'(merge(32'(cur_ff.en),
                        avs_req_i.writedata, avs_req_i.byteenable));
                CIE_OFS_FLAGS:
                    nxt_ff.flags = cur_ff.flags & ~NUM_SRC'(merge(32'h0,
                        avs_req_i.writedata,
                        avs_req_i.byteenable));
                CIE_OFS_SP:
                    nxt_ff.sp = 16'(merge(32'(cur_ff.sp),
                        avs_req_i.writedata, avs_req_i.byteenable));
                default:
                begin
                end
            endcase
        end

        // instruction-driven global enable changes
        if (cpu_i.boundary && cpu_i.op_sei)
        begin
            nxt_ff.gie = 1'b1;
        end
        if (cpu_i.op_cli)
        begin
            nxt_ff.gie = 1'b0;
        end

        unique case (cur_ff.st)
            CIE_ST_RESET:
            begin
                nxt_ff.pc_load = 1'b1;
                nxt_ff.pc_val = rst_vec;
                nxt_ff.st = CIE_ST_IDLE;
            end
            CIE_ST_IDLE:
            begin
                if (take)
                begin
                    nxt_ff.gie = 1'b0;
                    nxt_ff.idx = win_idx;
                    nxt_ff.ret_pc = cpu_pc_i;
                    nxt_ff.pc_val = vec_base
                        + 16'((32'(win_idx) + 32'h1) << 1);
                    nxt_ff.ack[win_idx] = ~LEVEL_MASK[win_idx];
                    nxt_ff.flags[win_idx] = 1'b0;
                    nxt_ff.cnt = 2'h0;
                    nxt_ff.st = cpu_i.sleeping ? CIE_ST_WAKE
                                               : CIE_ST_ENTRY;
                end
                else if (cpu_i.boundary && cpu_i.op_return_from_handler_op)
                begin
                    nxt_ff.cnt = 2'h0;
                    nxt_ff.st = CIE_ST_RETURN;
                end
            end
            CIE_ST_WAKE:
            begin
                // extra wait while the core clock settles
                nxt_ff.cnt = cur_ff.cnt + 2'h1;
                if (cur_ff.cnt == CIE_WAKE_LAST)
                begin
                    nxt_ff.cnt = 2'h0;
                    nxt_ff.st = CIE_ST_ENTRY;
                end
            end
            CIE_ST_ENTRY:
            begin
                // only the return address goes on the stack
                nxt_ff.cnt = cur_ff.cnt + 2'h1;
                if (cur_ff.cnt < 2'h2)
                begin
                    nxt_ff.mem.we = 1'b1;
                    nxt_ff.mem.addr = cur_ff.sp;
                    nxt_ff.mem.wdata = (cur_ff.cnt == 2'h0)
                        ? cur_ff.ret_pc[7:0] : cur_ff.ret_pc[15:8];
                    nxt_ff.sp = cur_ff.sp - CIE_SP_STEP;
                end
                if (cur_ff.cnt == CIE_ENTRY_LAST - 2'h1)
                begin
                    nxt_ff.pc_load = 1'b1;
                end
                if (cur_ff.cnt == CIE_ENTRY_LAST)
                begin
                    nxt_ff.st = CIE_ST_IDLE;
                end
            end
            CIE_ST_RETURN:
            begin
                // memory answers in the same cycle as the read strobe
                nxt_ff.cnt = cur_ff.cnt + 2'h1;
                if (cur_ff.cnt < 2'h2)
                begin
                    nxt_ff.mem.re = 1'b1;
                    nxt_ff.mem.addr = cur_ff.sp
                        + 16'(cur_ff.cnt) + CIE_SP_STEP;
                end
                if (cur_ff.cnt == 2'h1)
                begin
                    nxt_ff.pop_hi = mem_rdata_i;
                end
                if (cur_ff.cnt == CIE_RETURN_LAST - 2'h1)
                begin
                    nxt_ff.pc_load = 1'b1;
                    nxt_ff.pc_val = {cur_ff.pop_hi, mem_rdata_i};
                    nxt_ff.sp = cur_ff.sp + CIE_SP_POP_ALL;
                    nxt_ff.gie = 1'b1;
                end
                if (cur_ff.cnt == CIE_RETURN_LAST)
                begin
                    nxt_ff.st = CIE_ST_IDLE;
                end
            end
            default:
                nxt_ff.st = CIE_ST_IDLE;
        endcase

        // new events win over any clear in the same cycle
        nxt_ff.flags = nxt_ff.flags | (src_event_i & ~LEVEL_MASK);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cur_ff <= '0;
            cur_ff.st <= CIE_ST_RESET;
            cur_ff.sp <= CIE_SP_RESET;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // outputs
    assign avs_waitrequest_o = bus_req && !cur_ff.bus_ack;
    assign avs_readdata_o = cur_ff.rdata;
    assign src_ack_o = cur_ff.ack;
    assign cpu_stall_o = cur_ff.st != CIE_ST_IDLE;
    assign cpu_wake_o = cur_ff.st == CIE_ST_WAKE;
    assign pc_load_o = cur_ff.pc_load;
    assign pc_value_o = cur_ff.pc_val;
    assign sp_o = cur_ff.sp;
    assign global_enable_o = cur_ff.gie;
    assign mem_o = cur_ff.mem;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_take_enabled: assert property (
        take |-> cur_ff.gie && cur_ff.en[win_idx])
        else $error("interrupt taken while disabled");
    chk_lock_blocks: assert property (
        lock_sup |-> !take)
        else $error("interrupt taken under section lock");
    chk_lowest_wins: assert property (
        take |-> (req & ~({NUM_SRC{1'b1}} << win_idx)) == '0)
        else $error("lower priority source chosen");
    chk_vector_addr: assert property (
        take && !cpu_i.sleeping |-> ##4 pc_load_o && pc_value_o ==
            $past(vec_base, 4) + 16'((32'($past(win_idx, 4)) + 32'h1) << 1))
        else $error("wrong vector address");
    chk_reset_vector: assert property (
        cur_ff.st == CIE_ST_RESET |=> pc_load_o && pc_value_o == rst_vec)
        else $error("wrong reset vector");
    chk_gie_cleared: assert property (
        take |=> !global_enable_o && cpu_stall_o)
        else $error("global enable not cleared on entry");
    chk_cli_immediate: assert property (
        cpu_i.op_cli |-> !take ##1 !global_enable_o)
        else $error("interrupt taken with global disable");
    chk_ack_strobe: assert property (
        take && !LEVEL_MASK[win_idx] |=> src_ack_o != '0 ##1 src_ack_o == '0)
        else $error("acknowledge not a single pulse");
    chk_entry_time: assert property (
        take && !cpu_i.sleeping |-> !pc_load_o [*4] ##1 pc_load_o)
        else $error("entry not four cycles");
    chk_wake_time: assert property (
        take && cpu_i.sleeping |=> cpu_wake_o [*4] ##4 pc_load_o)
        else $error("wake entry not eight cycles");
    chk_push_two: assert property (
        take && !cpu_i.sleeping |-> ##3 sp_o == $past(sp_o, 3) - 16'h0002)
        else $error("stack pointer not lowered by two");
    chk_return_time: assert property (
        cur_ff.st == CIE_ST_IDLE && !take && cpu_i.boundary
            && cpu_i.op_return_from_handler_op |-> ##4 pc_load_o && global_enable_o
            && sp_o == $past(sp_o, 4) + 16'h0002)
        else $error("return sequence wrong");

endmodule

/* File: hdl/cie_pkg.sv */
// Notes on behaviour
// - take a source only when its enable and the global enable are both one
// - lock bits may suppress interrupts depending on where the program runs
// - lower vector address wins; reset first, external request zero next
// - vectors start at zero, or at boot start when vector base select is one
// - boot reset fuse moves the reset vector to the boot section start
// - accepting an interrupt clears the global enable
// - software may set the global enable in a handler to allow nesting
// - return from handler sets the global enable
// - hardware clears a flag-type pending flag when vectoring to it
// - writing one to a flag clears it, writing zero leaves it
// - a flag set while its source is disabled stays until enabled or cleared
// - flags raised with global enable off wait and are served by priority
// - level sources request only while their condition is present
// - after a return one instruction runs before any pending interrupt
// - status is never saved or restored, only the program counter
// - global disable acts at once, even on a request in the same cycle
// - after global enable the next instruction runs before any interrupt
// - entry takes four cycles pushing the program counter, then the vector
// - a multi-cycle instruction completes before entry begins
// - waking from sleep adds four cycles to the entry
// - return takes four cycles, pops two bytes, adds two to stack pointer
// - the program counter is 16 bits, addressing 64K words
// - each entry push lowers the stack pointer by one, two in total
package cie_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and cycle counts
    localparam int CIE_PC_W = 16;
    localparam int CIE_ENTRY_CYCLES = 4;
    localparam int CIE_WAKE_CYCLES = 4;
    localparam int CIE_RETURN_CYCLES = 4;
    localparam logic [1:0] CIE_ENTRY_LAST = 2'(CIE_ENTRY_CYCLES - 1);
    localparam logic [1:0] CIE_WAKE_LAST = 2'(CIE_WAKE_CYCLES - 1);
    localparam logic [1:0] CIE_RETURN_LAST = 2'(CIE_RETURN_CYCLES - 1);
    localparam logic [15:0] CIE_SP_STEP = 16'h0001;
    localparam logic [15:0] CIE_SP_POP_ALL = 16'h0002;
    localparam logic [15:0] CIE_APP_VEC_BASE = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [7:0] CIE_OFS_CTRL = 8'h00;
    localparam logic [7:0] CIE_OFS_ENABLE = 8'h04;
    localparam logic [7:0] CIE_OFS_FLAGS = 8'h08;
    localparam logic [7:0] CIE_OFS_STATUS = 8'h0C;
    localparam logic [7:0] CIE_OFS_SP = 8'h10;
    localparam int CIE_CTRL_GIE_BIT = 0;
    localparam int CIE_CTRL_VSEL_BIT = 1;
    localparam logic [15:0] CIE_SP_RESET = 16'h0000;
    localparam logic [31:0] CIE_UNMAPPED_VAL = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [2:0] {
        CIE_ST_RESET = 3'h0,
        CIE_ST_IDLE = 3'h1,
        CIE_ST_WAKE = 3'h2,
        CIE_ST_ENTRY = 3'h3,
        CIE_ST_RETURN = 3'h4
    } cie_state_type;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } cie_avs_req_type;

    // pipeline status seen at each cycle
    typedef struct packed {
        logic boundary;
        logic op_sei;
        logic op_cli;
        logic op_return_from_handler_op;
        logic sleeping;
        logic [15:0] ret_pc;
    } cie_cpu_type;

    // stack access toward data memory
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cie_mem_type;

endpackage

/* File: tb/cie_stack_model.sv */
module cie_stack_model
(
    // clock
    input wire logic sys_clk_i,
    // stack access from the core
    input wire cie_pkg::cie_mem_type mem_i,
    output logic [7:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import cie_pkg::*;

    logic [7:0] ram [0:255];
    logic [7:0] last_ff = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // byte-wide stack ram, only the low address byte is decoded
    always_ff @(posedge sys_clk_i)
    begin
        if (mem_i.we)
            ram[mem_i.addr[7:0]] <= mem_i.wdata;
        if (mem_i.re)
            last_ff <= ram[mem_i.addr[7:0]];
    end

    // outside a read the line shows the inverse, so stale data never passes
    assign mem_rdata_o = mem_i.re ? ram[mem_i.addr[7:0]] : ~last_ff;
endmodule

/* File: tb/test_cie_core.sv */
module test_cie_core;
    timeunit 1ns;
    timeprecision 1ns;
    import cie_pkg::*;

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    failures++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end

    localparam logic [15:0] BOOT = 16'hF000;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    cie_avs_req_type req = '0;
    logic [31:0] rdata;
    logic wreq;
    logic fuse = 1'b1;
    logic app_lock = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [7:0] lvl = 8'h00;
    cie_cpu_type cpu = '0;
    logic [15:0] cpu_pc = 16'h1234;
    logic [7:0] ack;
    logic stall, wake, pc_load, gie;
    logic [15:0] pc_val, sp;
    cie_mem_type mem;
    logic [7:0] mem_rd;
    int failures = 0;
    int n_compared = 0;
    int n;
    logic [7:0] ack_s;
    logic gie_s, wake_s;
    logic [31:0] q;

    cie_core #(.BOOT_START(BOOT), .LEVEL_MASK(8'h80)) i_dut (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .boot_reset_fuse_i(fuse),
        .app_section_lock_bit_i(app_lock), .boot_section_lock_bit_i(1'b0),
        .src_event_i(ev), .src_level_i(lvl), .src_ack_o(ack),
        .cpu_i(cpu), .cpu_pc_i(cpu_pc), .cpu_stall_o(stall),
        .cpu_wake_o(wake), .pc_load_o(pc_load), .pc_value_o(pc_val),
        .sp_o(sp), .global_enable_o(gie), .mem_o(mem),
        .mem_rdata_i(mem_rd));

    cie_stack_model i_stack (.sys_clk_i(sys_clk_i), .mem_i(mem),
        .mem_rdata_o(mem_rd));

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial
    begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one avalon access; starts one edge later so strobes never double up
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk_i);
        req.read <= ~wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= 4'hF;
        req.writedata <= d;
        for (i = 0; i < 50; i++)
        begin
            @(posedge sys_clk_i);
            if (wreq === 1'b0)
                break;
        end
        if (i == 50)
        begin
            failures++;
            report_and_stop();
        end
        q = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    // waits for a pc load; a bound that runs out is fatal only if must
    task wait_load(input int lim, input bit must, output int k);
        for (k = 1; k <= lim; k++)
        begin
            @(posedge sys_clk_i);
            #1;
            if (k == 1)
            begin
                ack_s = ack;
                gie_s = gie;
            end
            if (k == 3)
                wake_s = wake;
            if (pc_load === 1'b1)
                break;
        end
        if (must && k > lim)
        begin
            failures++;
            report_and_stop();
        end
    endtask

    task pulse(input logic [7:0] m);
        @(posedge sys_clk_i);
        ev <= m;
        @(posedge sys_clk_i);
        ev <= 8'h00;
    endtask

    // ops is {sei, cli, return_from_handler_op} completing in one boundary cycle
    task op(input logic [2:0] ops);
        @(posedge sys_clk_i);
        {cpu.op_sei, cpu.op_cli, cpu.op_return_from_handler_op} <= ops;
        @(posedge sys_clk_i);
        {cpu.op_sei, cpu.op_cli, cpu.op_return_from_handler_op} <= 3'b000;
    endtask

    task do_reset(input logic f, input logic [15:0] vec);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        fuse <= f;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wait_load(4, 1, n);
        `CHK("reset load delay", 1, n)
        `CHK("reset vector", vec, pc_val)
    endtask

    task return_from_handler_op_chk(input logic [15:0] pc, input logic [15:0] s);
        op(3'b001);
        wait_load(10, 1, n);
        `CHK("return delay", 3, n)
        `CHK("return pc", pc, pc_val)
        `CHK("return gie", 1'b1, gie)
        `CHK("return sp", s, sp)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        cpu.boundary <= 1'b1;
        do_reset(1'b1, BOOT);
        do_reset(1'b0, 16'h0000);
        bus(1'b0, 8'h20, '0);
        `CHK("unmapped read", CIE_UNMAPPED_VAL, q)
        bus(1'b0, CIE_OFS_SP, '0);
        `CHK("sp reset", 32'h0, q)
        bus(1'b1, CIE_OFS_SP, 32'h0000_0080);
        bus(1'b1, CIE_OFS_ENABLE, 32'h0000_00DF);
        pulse(8'h2A);
        bus(1'b0, CIE_OFS_FLAGS, '0);
        `CHK("flags held", 32'h2A, q)
        // three pending flags, two enabled: the lower index goes first
        bus(1'b1, CIE_OFS_CTRL, 32'h1);
        wait_load(20, 1, n);
        `CHK("entry delay", 4, n)
        `CHK("first vector", 16'h0004, pc_val)
        `CHK("ack strobe", 8'h02, ack_s)
        `CHK("gie cleared", 1'b0, gie_s)
        `CHK("sp after push", 16'h007E, sp)
        `CHK("push low", 8'h34, i_stack.ram[8'h80])
        `CHK("push high", 8'h12, i_stack.ram[8'h7F])
        bus(1'b0, CIE_OFS_FLAGS, '0);
        `CHK("flag cleared", 32'h28, q)
        return_from_handler_op_chk(16'h1234, 16'h0080);
        wait_load(20, 1, n);
        `CHK("next pending", 16'h0008, pc_val)
        // nesting from inside the handler
        bus(1'b1, CIE_OFS_CTRL, 32'h1);
        pulse(8'h10);
        wait_load(20, 1, n);
        `CHK("nested vector", 16'h000A, pc_val)
        `CHK("nested sp", 16'h007C, sp)
        return_from_handler_op_chk(16'h1234, 16'h007E);
        bus(1'b1, CIE_OFS_FLAGS, 32'h0);
        bus(1'b0, CIE_OFS_FLAGS, '0);
        `CHK("zero write", 32'h20, q)
        bus(1'b1, CIE_OFS_FLAGS, 32'h20);
        bus(1'b0, CIE_OFS_FLAGS, '0);
        `CHK("one write", 32'h0, q)
        // disable lands in the very cycle the request appears
        @(posedge sys_clk_i);
        ev <= 8'h01;
        @(posedge sys_clk_i);
        ev <= 8'h00;
        cpu.op_cli <= 1'b1;
        @(posedge sys_clk_i);
        cpu.op_cli <= 1'b0;
        wait_load(12, 0, n);
        `CHK("no take after cli", 13, n)
        `CHK("gie after cli", 1'b0, gie)
        bus(1'b1, CIE_OFS_CTRL, 32'h2);
        op(3'b100);
        wait_load(20, 1, n);
        `CHK("sei delay", 4, n)
        `CHK("boot vector", 16'hF002, pc_val)
        return_from_handler_op_chk(16'h1234, 16'h007E);
        // sleeping core: no boundary, wake cycles added
        @(posedge sys_clk_i);
        cpu.sleeping <= 1'b1;
        cpu.boundary <= 1'b0;
        pulse(8'h40);
        wait_load(20, 1, n);
        `CHK("sleep delay", 8, n)
        `CHK("wake level", 1'b1, wake_s)
        `CHK("sleep vector", 16'hF00E, pc_val)
        `CHK("sleep ack", 8'h40, ack_s)
        @(posedge sys_clk_i);
        cpu.sleeping <= 1'b0;
        cpu.boundary <= 1'b1;
        return_from_handler_op_chk(16'h1234, 16'h007E);
        // running in the boot section with app vectors locked
        @(posedge sys_clk_i);
        app_lock <= 1'b1;
        cpu_pc <= 16'hF100;
        bus(1'b1, CIE_OFS_CTRL, 32'h1);
        pulse(8'h01);
        wait_load(12, 0, n);
        `CHK("locked", 13, n)
        @(posedge sys_clk_i);
        cpu.boundary <= 1'b0;
        app_lock <= 1'b0;
        wait_load(6, 0, n);
        `CHK("mid instruction", 7, n)
        @(posedge sys_clk_i);
        cpu.boundary <= 1'b1;
        wait_load(20, 1, n);
        `CHK("unlocked vector", 16'h0002, pc_val)
        `CHK("pc high byte", 8'hF1, i_stack.ram[8'h7D])
        // a level that vanishes while disabled never fires
        @(posedge sys_clk_i);
        lvl <= 8'h80;
        @(posedge sys_clk_i);
        lvl <= 8'h00;
        bus(1'b1, CIE_OFS_CTRL, 32'h1);
        wait_load(8, 0, n);
        `CHK("level gone", 9, n)
        @(posedge sys_clk_i);
        lvl <= 8'h80;
        wait_load(20, 1, n);
        `CHK("level vector", 16'h0010, pc_val)
        `CHK("level no ack", 8'h00, ack_s)
        report_and_stop();
    end
endmodule
